// *** verilog/isr_status_bank.sv ***
// status flag register bank with bus condition watcher
`timescale 1ns/1ps
module isr_status_bank (
  clk,
  nrst,
  addr,
  wdata,
  wr_en,
  rd_en,
  rdata,
  scl_in,
  sda_in,
  engine_ev,
  ctrl,
  irq
);
  import isr_pkg::*;
  input wire logic clk;
  input wire logic nrst;
  input wire logic [isr_pkg::ADDR_W-1:0] addr;
  input wire logic [isr_pkg::DATA_W-1:0] wdata;
  input wire logic wr_en;
  input wire logic rd_en;
  output logic [isr_pkg::DATA_W-1:0] rdata;
  input wire logic scl_in;
  input wire logic sda_in;
  input wire isr_pkg::isr_engine_ev_t engine_ev;
  output isr_pkg::isr_ctrl_t ctrl;
  output logic irq;

  logic [14:0] str_q;
  logic [6:0] ier_q;
  logic [15:0] mdr_q;
  logic [7:0] rx_q;
  logic rx_full_q;
  logic tx_loaded_q;
  logic [7:0] tx_q;
  logic rep_start_q;
  logic irq_q;
  logic [31:0] rdata_q;
  logic [2:0] scl_s_q;
  logic [2:0] sda_s_q;
  logic scl_f_q;
  logic sda_f_q;
  logic start_det;
  logic stop_det;
  logic run;
  logic wr_str;
  logic wr_mdr;
  logic [14:0] w1c;

  // one-hot address match shared by read and write decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // strobes and decode
  assign run = mdr_q[M_RUN];
  assign wr_str = wr_en && hit(addr, OFS_STR);
  assign wr_mdr = wr_en && hit(addr, OFS_MDR);
  assign w1c = wr_str ? (wdata[14:0] & STR_W1C) : 15'h0000;

  // three-stage pin samplers; stage one feeds stage two only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_s_q <= SYNC_RST;
      sda_s_q <= SYNC_RST;
    end else begin
      scl_s_q <= {scl_s_q[1:0], scl_in};
      sda_s_q <= {sda_s_q[1:0], sda_in};
    end
  end

  // accept a level only once stages two and three agree
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
    end else begin
      if (scl_s_q[1] == scl_s_q[2]) begin
        scl_f_q <= scl_s_q[2];
      end
      if (sda_s_q[1] == sda_s_q[2]) begin
        sda_f_q <= sda_s_q[2];
      end
    end
  end

  // data edges while clock stays high mark START and STOP
  assign start_det = scl_f_q && sda_f_q && !sda_s_q[2] && (sda_s_q[1] == sda_s_q[2])
                     && scl_s_q[2];
  assign stop_det = scl_f_q && !sda_f_q && sda_s_q[2] && (sda_s_q[1] == sda_s_q[2])
                    && scl_s_q[2];

  // mode control, interrupt enables, transmit holder
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mdr_q <= MDR_RST;
      ier_q <= IER_RST;
      tx_q <= BYTE_RST;
    end else begin
      if (wr_mdr) begin
        mdr_q <= wdata[15:0];
      end
      if (wr_en && hit(addr, OFS_IER)) begin
        ier_q <= wdata[6:0];
      end
      if (wr_en && hit(addr, OFS_DXR)) begin
        tx_q <= wdata[7:0];
      end
    end
  end

  // repeated start pulse for the engine
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rep_start_q <= 1'b0;
    end else begin
      rep_start_q <= wr_mdr && wdata[M_START] && str_q[B_BB] && run;
    end
  end

  // receive holder; a new byte is dropped while the old one is unread
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_q <= BYTE_RST;
      rx_full_q <= 1'b0;
    end else if (!run) begin
      rx_full_q <= 1'b0;
    end else if (engine_ev.rx_byte_valid && !rx_full_q) begin
      rx_q <= engine_ev.rx_byte;
      rx_full_q <= 1'b1;
    end else if (rd_en && hit(addr, OFS_DRR)) begin
      rx_full_q <= 1'b0;
    end
  end

  // transmit holder loaded since the last shifter transfer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_loaded_q <= 1'b0;
    end else if (!run) begin
      tx_loaded_q <= 1'b0;
    end else if (wr_en && hit(addr, OFS_DXR)) begin
      tx_loaded_q <= 1'b1;
    end else if (engine_ev.tx_xfer) begin
      tx_loaded_q <= 1'b0;
    end
  end

  // event flags: set beats a same-cycle clear, except loopback, which holds the direction flag clear over slave_tx
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      str_q <= STR_RST;
    end else if (!run) begin
      str_q <= STR_RST;
    end else begin
      str_q[B_AL] <= engine_ev.arb_lost | (str_q[B_AL] & ~w1c[B_AL]);
      str_q[B_NACK] <= engine_ev.nack_rcvd | (str_q[B_NACK] & ~w1c[B_NACK]);
      str_q[B_ACCESS_READY_FLAG] <= engine_ev.access_rdy | (str_q[B_ACCESS_READY_FLAG] & ~w1c[B_ACCESS_READY_FLAG]);
      str_q[B_RRDY] <= engine_ev.rx_rdy | (str_q[B_RRDY] & ~w1c[B_RRDY]);
      str_q[B_XRDY] <= engine_ev.tx_rdy | (str_q[B_XRDY] & ~w1c[B_XRDY]);
      str_q[B_SCD] <= stop_det | engine_ev.stop_sent | (str_q[B_SCD] & ~w1c[B_SCD]);
      str_q[B_GC] <= engine_ev.gen_call;
      str_q[B_AAS] <= engine_ev.addr_slave;
      // overrun on byte into full holder
      if (engine_ev.rx_byte_valid && rx_full_q) begin
        str_q[B_OVR] <= 1'b1;
      end else if (rd_en && hit(addr, OFS_DRR)) begin
        str_q[B_OVR] <= 1'b0;
      end
      if (wr_en && hit(addr, OFS_DXR)) begin
        str_q[B_TX_NOT_UNDERFLOW_FLAG] <= 1'b1;
      end else if (engine_ev.tx_shift_empty && !tx_loaded_q) begin
        str_q[B_TX_NOT_UNDERFLOW_FLAG] <= 1'b0;
      end
      str_q[B_NSNT] <= engine_ev.nack_driven | (str_q[B_NSNT] & ~w1c[B_NSNT]);
      // start seen or sent sets busy
      // low clock line sets busy; set beats clear while held low
      str_q[B_BB] <= start_det | engine_ev.start_sent | !scl_f_q
                     | (str_q[B_BB] & ~(stop_det | engine_ev.stop_sent | w1c[B_BB]));
      if (mdr_q[M_LOOP]) begin
        str_q[B_SLAVE_TX_DIRECTION] <= 1'b0;
      end else if (engine_ev.slave_tx) begin
        str_q[B_SLAVE_TX_DIRECTION] <= 1'b1;
      end else if (start_det || stop_det || engine_ev.start_sent || engine_ev.stop_sent
                   || w1c[B_SLAVE_TX_DIRECTION]) begin
        str_q[B_SLAVE_TX_DIRECTION] <= 1'b0;
      end
    end
  end

  // interrupt request, registered so the pin never glitches
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (|(str_q[B_SCD:B_AL] & ier_q[5:0])) | (str_q[B_AAS] & ier_q[6]);
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 32'h00000000;
    end else if (rd_en && hit(addr, OFS_STR)) begin
      rdata_q <= {17'h00000, str_q};
    end else if (rd_en && hit(addr, OFS_IER)) begin
      rdata_q <= {25'h0000000, ier_q};
    end else if (rd_en && hit(addr, OFS_MDR)) begin
      rdata_q <= {16'h0000, mdr_q};
    end else if (rd_en && hit(addr, OFS_DRR)) begin
      rdata_q <= {24'h000000, rx_q};
    end else begin
      rdata_q <= 32'h00000000;
    end
  end

  // outputs straight from flops
  assign rdata = rdata_q;
  assign irq = irq_q;
  assign ctrl = {mdr_q[M_RUN], mdr_q[M_START], mdr_q[M_NACK], mdr_q[M_LOOP], rep_start_q,
                 tx_q};
endmodule

// *** verilog/isr_pkg.sv ***
// package: offsets, field positions, reset values and carriers of the status flag bank
package isr_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register byte offsets
  localparam logic [7:0] OFS_IER = 8'h04;
  localparam logic [7:0] OFS_STR = 8'h08;
  localparam logic [7:0] OFS_DRR = 8'h18;
  localparam logic [7:0] OFS_DXR = 8'h20;
  localparam logic [7:0] OFS_MDR = 8'h24;
  // status field positions
  localparam int B_AL = 0;
  localparam int B_NACK = 1;
  localparam int B_ACCESS_READY_FLAG = 2;
  localparam int B_RRDY = 3;
  localparam int B_XRDY = 4;
  localparam int B_SCD = 5;
  localparam int B_GC = 8;
  localparam int B_AAS = 9;
  localparam int B_TX_NOT_UNDERFLOW_FLAG = 10;
  localparam int B_OVR = 11;
  localparam int B_BB = 12;
  localparam int B_NSNT = 13;
  localparam int B_SLAVE_TX_DIRECTION = 14;
  localparam int STR_W = 15;
  localparam int IER_W = 7;
  // status value after reset: underflow-absent and tx ready high
  localparam logic [14:0] STR_RST = 15'h0410;
  // write-one-to-clear bits
  localparam logic [14:0] STR_W1C = 15'h703F;
  // mode control field positions
  localparam int M_LOOP = 3;
  localparam int M_RUN = 5;
  localparam int M_START = 13;
  localparam int M_NACK = 15;
  localparam logic [15:0] MDR_RST = 16'h0000;
  localparam logic [6:0] IER_RST = 7'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [2:0] SYNC_RST = 3'h7;

  // pulses and levels from the transfer engine, same clock
  typedef struct packed {
    logic arb_lost;
    logic nack_rcvd;
    logic access_rdy;
    logic rx_rdy;
    logic tx_rdy;
    logic start_sent;
    logic stop_sent;
    logic nack_driven;
    logic slave_tx;
    logic addr_slave;
    logic gen_call;
    logic rx_byte_valid;
    logic [7:0] rx_byte;
    logic tx_xfer;
    logic tx_shift_empty;
  } isr_engine_ev_t;

  // controls handed to the transfer engine
  typedef struct packed {
    logic module_run;
    logic start_request;
    logic force_nack;
    logic loopback;
    logic rep_start;
    logic [7:0] tx_data;
  } isr_ctrl_t;
endpackage

// *** dv/isr_status_bank_asserts.sv ***
// checker: port assertions for the status flag bank
`timescale 1ns/1ps
module isr_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [isr_pkg::ADDR_W-1:0] addr,
  input wire logic [isr_pkg::DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [isr_pkg::DATA_W-1:0] rdata,
  input wire isr_pkg::isr_engine_ev_t engine_ev,
  input wire isr_pkg::isr_ctrl_t ctrl
);
  import isr_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // bus strobes decoded once
  wire rs = rd_en && addr == OFS_STR;
  wire ws = wr_en && addr == OFS_STR;
  wire run = ctrl.module_run;
  property p_rsv; rs |=> rdata[31:15] == 17'h0 && rdata[7:6] == 2'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_bb; !run && $past(!run) && rs |=> !rdata[B_BB]; endproperty
  a_bb: assert property (p_bb) else $error("busy while stopped");
  property p_ns; !run && $past(!run) && rs |=> !rdata[B_NSNT]; endproperty
  a_ns: assert property (p_ns) else $error("nack flag while stopped");
  property p_lp; ctrl.loopback && $past(ctrl.loopback) && rs |=> !rdata[B_SLAVE_TX_DIRECTION]; endproperty
  a_lp: assert property (p_lp) else $error("direction set in loopback");
  property p_sd; ws && wdata[B_SLAVE_TX_DIRECTION] && !engine_ev.slave_tx ##[1:2] rs |=> !rdata[B_SLAVE_TX_DIRECTION];
  endproperty
  a_sd: assert property (p_sd) else $error("direction not cleared");
  property p_nk; ws && wdata[B_NSNT] && !engine_ev.nack_driven ##[1:2] rs |=> !rdata[B_NSNT];
  endproperty
  a_nk: assert property (p_nk) else $error("nack flag not cleared");
  property p_run; wr_en && addr == OFS_MDR |=> run == $past(wdata[M_RUN]); endproperty
  a_run: assert property (p_run) else $error("run bit wrong");
  property p_tx; wr_en && addr == OFS_DXR |=> ctrl.tx_data == $past(wdata[7:0]); endproperty
  a_tx: assert property (p_tx) else $error("tx byte wrong");
  // main flags seen on reads
  c_bb: cover property (rs ##1 rdata[B_BB]);
  c_sd: cover property (rs ##1 rdata[B_SLAVE_TX_DIRECTION]);
  c_ns: cover property (rs ##1 rdata[B_NSNT]);
endmodule
bind isr_status_bank isr_chk i_chk (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
  .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .engine_ev(engine_ev), .ctrl(ctrl));

// *** dv/isr_i2c_peer.sv ***
// partner: bus peer making start, stop and clock-low conditions
`timescale 1ns/1ps
module isr_i2c_peer (
  output logic scl,
  output logic sda
);
  // lines idle high, as pulled up; odd offsets keep every edge off the clock except the scl rise in low, which lands on an edge
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic start();
    #41 sda = 1'b0;
    #41;
  endtask
  task automatic stop();
    #41 sda = 1'b1;
    #41;
  endtask
  task automatic low();
    #41 scl = 1'b0;
    #81 scl = 1'b1;
    #41;
  endtask
endmodule

// *** dv/isr_status_bank_bench.sv ***
// bench: scenarios for the status flag bank
`timescale 1ns/1ps
module isr_status_bank_bench;
  import isr_pkg::*;
  logic clk = 0, nrst = 0, wr_en = 0, rd_en = 0, rd_q = 0, scl_in, sda_in, irq;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata;
  isr_engine_ev_t ev = '0;
  isr_ctrl_t ctrl;
  logic [63:0] q[$], e;
  int error_cnt = 0, cmp_count = 0, seed = 32'h16BBF007;
  initial forever #2 clk = ~clk;
  isr_i2c_peer i_peer (.scl(scl_in), .sda(sda_in));
  isr_status_bank i_dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .scl_in(scl_in), .sda_in(sda_in), .engine_ev(ev),
    .ctrl(ctrl), .irq(irq));
  task automatic check(string n, logic [31:0] x, logic [31:0] s);
    cmp_count++;
    if (s !== x) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  // status read; expected value and mask queued for the monitor
  task automatic rd(logic [31:0] x, logic [31:0] m);
    q.push_back({m, x});
    @(posedge clk);
    addr <= OFS_STR;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
  endtask
  // one-cycle engine event on struct bit b
  task automatic pl(int b);
    isr_engine_ev_t v;
    v = '0;
    v[b] = 1'b1;
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= '0;
  endtask
  task automatic fin(string s);
    repeat (3) @(posedge clk);
    if (q.size() != 0) begin
      error_cnt++;
      $display("[FAIL] read queue expected 0 seen %0d", q.size());
    end
    $display("test %s done", s);
  endtask
  // monitor: read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    rd_q <= rd_en && addr == OFS_STR;
    if (rd_q) begin
      e = q.pop_front();
      check("event_status", e[31:0], rdata & e[63:32]);
    end
  end
  // hang guard
  initial begin
    #100000;
    error_cnt++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd(32'h410, '1);
    wr(OFS_STR, 32'h0);
    rd(32'h410, '1);
    wr(OFS_MDR, 32'h20);
    wr(OFS_IER, 32'h10);
    pl(17);
    repeat (2) @(posedge clk);
    check("irq", 32'h1, {31'h0, irq});
    wr(OFS_STR, $random(seed) | 32'hFFFF8F3F);
    rd(32'h400, '1);
    repeat (2) @(posedge clk);
    check("irq", 32'h0, {31'h0, irq});
    wr(OFS_DXR, $random(seed));
    fin("regs");
    wr(OFS_MDR, 32'h20);
    i_peer.start();
    rd(32'h1000, 32'h1000);
    i_peer.stop();
    rd(32'h0, 32'h1000);
    i_peer.start();
    wr(OFS_STR, 32'h1000);
    rd(32'h0, 32'h1000);
    i_peer.stop();
    i_peer.low();
    rd(32'h1000, 32'h1000);
    fin("busy");
    pl(13);
    rd(32'h4000, 32'h4000);
    i_peer.start();
    rd(32'h0, 32'h4000);
    pl(13);
    wr(OFS_STR, 32'h4000);
    rd(32'h0, 32'h4000);
    pl(14);
    rd(32'h2000, 32'h2000);
    wr(OFS_STR, 32'h2000);
    rd(32'h0, 32'h2000);
    pl(14);
    wr(OFS_MDR, 32'h28);
    pl(13);
    rd(32'h2000, 32'h6000);
    wr(OFS_MDR, 32'h0);
    rd(32'h0, 32'h3000);
    fin("flags");
    close_out();
  end
endmodule
